// File: rtl/ppe_bank.sv
// AHB-Lite register bank for per-port PLL enables, indirect registers and design id
`include "ppe_defines.svh"
`default_nettype none
module ppe_bank #(
  parameter bit HAS_INDIRECT = 1'b1,     // Optional extended package
  parameter logic [15:0] DESIGN_ID = 16'h5a00 // Arbitrary value
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Lock inputs
  input wire logic p0_rx_lock_i,
  input wire logic p0_sys_lock_i,
  input wire logic p1_rx_lock_i,
  input wire logic p1_sys_lock_i,
  // Port 0 controls
  output logic p0_xcvr_run_o,
  output logic p0_dpll_run_o,
  output logic p0_sys_pll_en_o,
  output logic p0_ram_run_o,
  // Port 1 controls
  output logic p1_xcvr_run_o,
  output logic p1_dpll_run_o,
  output logic p1_sys_pll_en_o,
  // Interrupt
  output logic irq_o
);
  // ***************************************
  // Declarations
  // ***************************************
  ppe_port_if p0_if ();                 // Port 0 slice link
  ppe_port_if p1_if ();                 // Port 1 slice link
  logic [3:0] p0_ctrl;                  // Port 0 control bits
  logic [3:0] p1_ctrl;                  // Port 1 control bits
  ppe_pkg::ppe_sel_t sel_q;             // Data-phase target
  ppe_pkg::ppe_sel_t sel_d;             // Address-phase decode
  logic wr_q;                           // Data phase is a write
  logic rd_pend_q;                      // Read needs a second cycle
  logic ready_q;                        // Registered ready
  logic [31:0] rdata_q;                 // Registered read data
  logic [23:0] ind_addr_q;              // Indirect address
  logic [7:0] ind_mem [`PPE_IND_DEPTH]; // Extended registers
  logic [7:0] ind_rd;                   // Indirect read byte
  logic [`PPE_IRQ_WIDTH-1:0] ist_q;     // Sticky lock events
  logic [`PPE_IRQ_WIDTH-1:0] imsk_q;    // Interrupt mask
  logic [`PPE_IRQ_WIDTH-1:0] lock_now;  // Present lock levels
  logic [`PPE_IRQ_WIDTH-1:0] lock_q;    // Lock levels last cycle
  logic [`PPE_IRQ_WIDTH-1:0] ist_clr;   // Write-one clear
  logic irq_q;                          // Registered interrupt
  logic [3:0] ctrl0_q;                  // Port 0 pins registered
  logic [2:0] ctrl1_q;                  // Port 1 pins registered
  logic wr_phase;                       // Write data phase now
  logic addr_ok;                        // Valid address phase
  logic [7:0] idx;                      // Register index

  // ***************************************
  // Port slices
  // ***************************************
  ppe_port_enable u_port0 (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .pif(p0_if.port),
    .ctrl_o(p0_ctrl)
  );

  // Same layout, base 0x10 higher
  ppe_port_enable u_port1 (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .pif(p1_if.port),
    .ctrl_o(p1_ctrl)
  );

  assign wr_phase = wr_q && ready_q;
  assign p0_if.wr_en = wr_phase && (sel_q == ppe_pkg::PPE_SEL_EN0);
  assign p1_if.wr_en = wr_phase && (sel_q == ppe_pkg::PPE_SEL_EN1);
  assign p0_if.wdata = hwdata_i[7:0];
  assign p1_if.wdata = hwdata_i[7:0];
  assign p0_if.rx_lock = p0_rx_lock_i;
  assign p0_if.sys_lock = p0_sys_lock_i;
  assign p1_if.rx_lock = p1_rx_lock_i;
  assign p1_if.sys_lock = p1_sys_lock_i;

  // ***************************************
  // Address decode
  // ***************************************
  assign addr_ok = hsel_i && hready_i && htrans_i[1];
  assign idx = haddr_i[9:2];

  // Map index to target; indirect absent without option
  always_comb begin
    sel_d = ppe_pkg::PPE_SEL_NONE;
    unique case (idx)
      `PPE_IDX_PORT0_ENABLE: sel_d = ppe_pkg::PPE_SEL_EN0;
      `PPE_IDX_PORT1_ENABLE: sel_d = ppe_pkg::PPE_SEL_EN1;
      `PPE_IDX_LOAD_WINDOW: sel_d = ppe_pkg::PPE_SEL_LOAD;
      `PPE_IDX_IND_ADDR_LO: sel_d = HAS_INDIRECT ? ppe_pkg::PPE_SEL_AL : ppe_pkg::PPE_SEL_NONE;
      `PPE_IDX_IND_ADDR_MID: sel_d = HAS_INDIRECT ? ppe_pkg::PPE_SEL_AM : ppe_pkg::PPE_SEL_NONE;
      `PPE_IDX_IND_ADDR_HI: sel_d = HAS_INDIRECT ? ppe_pkg::PPE_SEL_AH : ppe_pkg::PPE_SEL_NONE;
      `PPE_IDX_IND_DATA: sel_d = HAS_INDIRECT ? ppe_pkg::PPE_SEL_DATA : ppe_pkg::PPE_SEL_NONE;
      `PPE_IDX_DESIGN_ID: sel_d = ppe_pkg::PPE_SEL_ID;
      `PPE_IDX_IRQ_STATUS: sel_d = ppe_pkg::PPE_SEL_IST;
      `PPE_IDX_IRQ_MASK: sel_d = ppe_pkg::PPE_SEL_IMSK;
      default: sel_d = ppe_pkg::PPE_SEL_NONE;
    endcase
  end

  // ***************************************
  // Bus phase tracking
  // ***************************************
  // Reads take one wait state for registered data; writes none
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      sel_q <= ppe_pkg::PPE_SEL_NONE;
      wr_q <= 1'b0;
      rd_pend_q <= 1'b0;
      ready_q <= 1'b1;
    end else if (rd_pend_q) begin
      rd_pend_q <= 1'b0;
      ready_q <= 1'b1;
    end else if (ready_q) begin
      if (addr_ok) begin
        sel_q <= sel_d;
        wr_q <= hwrite_i;
        rd_pend_q <= !hwrite_i;
        ready_q <= hwrite_i;
      end else begin
        sel_q <= ppe_pkg::PPE_SEL_NONE;
        wr_q <= 1'b0;
      end
    end
  end

  // ***************************************
  // Indirect registers
  // ***************************************
  // Address bytes, lowest offset least significant
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ind_addr_q <= `PPE_IND_ADDR_RESET;
    end else if (wr_phase) begin
      if (sel_q == ppe_pkg::PPE_SEL_AL) begin
        ind_addr_q[7:0] <= hwdata_i[7:0];
      end else if (sel_q == ppe_pkg::PPE_SEL_AM) begin
        ind_addr_q[15:8] <= hwdata_i[7:0];
      end else if (sel_q == ppe_pkg::PPE_SEL_AH) begin
        ind_addr_q[23:16] <= hwdata_i[7:0];
      end
    end
  end

  // Extended register store; upper address bits alias
  always_ff @(posedge clk_sys_i) begin
    if (wr_phase && (sel_q == ppe_pkg::PPE_SEL_DATA)) begin
      ind_mem[ind_addr_q[`PPE_IND_AW-1:0]] <= hwdata_i[7:0];
    end
  end

  assign ind_rd = ind_mem[ind_addr_q[`PPE_IND_AW-1:0]];

  // ***************************************
  // Interrupts on lock changes
  // ***************************************
  assign lock_now = {p1_sys_lock_i, p1_rx_lock_i, p0_sys_lock_i, p0_rx_lock_i};
  assign ist_clr = (wr_phase && (sel_q == ppe_pkg::PPE_SEL_IST)) ?
                   hwdata_i[`PPE_IRQ_WIDTH-1:0] : `PPE_IRQ_RESET;

  // Sticky status; a new event beats a clear
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      lock_q <= `PPE_IRQ_RESET;
      ist_q <= `PPE_IRQ_RESET;
    end else begin
      lock_q <= lock_now;
      ist_q <= (ist_q & ~ist_clr) | (lock_q ^ lock_now);
    end
  end

  // Mask register
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      imsk_q <= `PPE_IRQ_RESET;
    end else if (wr_phase && (sel_q == ppe_pkg::PPE_SEL_IMSK)) begin
      imsk_q <= hwdata_i[`PPE_IRQ_WIDTH-1:0];
    end
  end

  // Level interrupt
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(ist_q & imsk_q);
    end
  end

  // ***************************************
  // Read data
  // ***************************************
  // Captured in the wait cycle; load window and unmapped read zero
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rdata_q <= 32'h00000000;
    end else if (rd_pend_q) begin
      unique case (sel_q)
        ppe_pkg::PPE_SEL_EN0: rdata_q <= {24'h000000, p0_if.rdata};
        ppe_pkg::PPE_SEL_EN1: rdata_q <= {24'h000000, p1_if.rdata};
        ppe_pkg::PPE_SEL_AL: rdata_q <= {24'h000000, ind_addr_q[7:0]};
        ppe_pkg::PPE_SEL_AM: rdata_q <= {24'h000000, ind_addr_q[15:8]};
        ppe_pkg::PPE_SEL_AH: rdata_q <= {24'h000000, ind_addr_q[23:16]};
        ppe_pkg::PPE_SEL_DATA: rdata_q <= {24'h000000, ind_rd};
        ppe_pkg::PPE_SEL_ID: rdata_q <= {16'h0000, DESIGN_ID};
        ppe_pkg::PPE_SEL_IST: rdata_q <= {28'h0000000, ist_q};
        ppe_pkg::PPE_SEL_IMSK: rdata_q <= {28'h0000000, imsk_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end

  // ***************************************
  // Control outputs
  // ***************************************
  // Registered copies of the enable bits
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ctrl0_q <= 4'h0;
      ctrl1_q <= 3'h0;
    end else begin
      ctrl0_q <= p0_ctrl;
      ctrl1_q <= p1_ctrl[2:0];
    end
  end

  assign p0_xcvr_run_o = ctrl0_q[`PPE_BIT_XCVR_EN];
  assign p0_dpll_run_o = ctrl0_q[`PPE_BIT_DPLL_EN];
  assign p0_sys_pll_en_o = ctrl0_q[`PPE_BIT_SYSTEM_PLL_ENABLE];
  assign p0_ram_run_o = ctrl0_q[`PPE_BIT_RAM_EN];
  assign p1_xcvr_run_o = ctrl1_q[`PPE_BIT_XCVR_EN];
  assign p1_dpll_run_o = ctrl1_q[`PPE_BIT_DPLL_EN];
  assign p1_sys_pll_en_o = ctrl1_q[`PPE_BIT_SYSTEM_PLL_ENABLE];
  assign hrdata_o = rdata_q;
  assign hreadyout_o = ready_q;
  assign hresp_o = 1'b0;
  assign irq_o = irq_q;
endmodule
`default_nettype wire

// File: rtl/ppe_defines.svh
// Register offsets, field positions, reset values and codes of the PLL enable bank
`ifndef PPE_DEFINES_SVH
`define PPE_DEFINES_SVH

// ***************************************
// Register offsets (printed indices; byte address is four times)
// ***************************************
`define PPE_IDX_PORT0_ENABLE 8'h24
`define PPE_IDX_PORT1_ENABLE 8'h34
`define PPE_IDX_LOAD_WINDOW 8'h40
`define PPE_IDX_IND_ADDR_LO 8'h60
`define PPE_IDX_IND_ADDR_MID 8'h61
`define PPE_IDX_IND_ADDR_HI 8'h62
`define PPE_IDX_IND_DATA 8'h63
`define PPE_IDX_DESIGN_ID 8'h7c
`define PPE_IDX_IRQ_STATUS 8'h70
`define PPE_IDX_IRQ_MASK 8'h71

// ***************************************
// Enable register fields
// ***************************************
`define PPE_BIT_XCVR_EN 0
`define PPE_BIT_DPLL_EN 1
`define PPE_BIT_SYSTEM_PLL_ENABLE 2
`define PPE_BIT_RAM_EN 3
`define PPE_BIT_SYS_LOCK 5
`define PPE_BIT_RX_LOCK 6
`define PPE_ENABLE_WMASK 8'h0f
`define PPE_ENABLE_RESET 8'h00

// ***************************************
// Interrupt status layout (lock changes)
// ***************************************
`define PPE_IRQ_P0_RX 0
`define PPE_IRQ_P0_SYS 1
`define PPE_IRQ_P1_RX 2
`define PPE_IRQ_P1_SYS 3
`define PPE_IRQ_WIDTH 4
`define PPE_IRQ_RESET 4'h0

// ***************************************
// Other values
// ***************************************
`define PPE_IND_ADDR_RESET 24'h000000
`define PPE_IND_DEPTH 256
`define PPE_IND_AW 8

`endif

// File: rtl/ppe_pkg.sv
// Types of the PLL enable register bank
`default_nettype none
package ppe_pkg;
  // Bus decode target
  typedef enum logic [3:0] {
    PPE_SEL_NONE, PPE_SEL_EN0, PPE_SEL_EN1, PPE_SEL_LOAD, PPE_SEL_AL,
    PPE_SEL_AM, PPE_SEL_AH, PPE_SEL_DATA, PPE_SEL_ID, PPE_SEL_IST, PPE_SEL_IMSK
  } ppe_sel_t;
endpackage
`default_nettype wire

// File: rtl/ppe_port_if.sv
// Interface between the bank and one port's enable slice
`default_nettype none
interface ppe_port_if;
  logic wr_en;        // Write strobe for the enable register
  logic [7:0] wdata;  // Write byte
  logic rx_lock;      // Receive PLL lock input
  logic sys_lock;     // System PLL lock input
  logic [7:0] rdata;  // Read-back value
  modport bank (output wr_en, output wdata, output rx_lock, output sys_lock, input rdata);
  modport port (input wr_en, input wdata, input rx_lock, input sys_lock, output rdata);
endinterface
`default_nettype wire

// File: rtl/ppe_port_enable.sv
// One port's enable register with lock read-back
`include "ppe_defines.svh"
`default_nettype none
module ppe_port_enable (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  ppe_port_if.port pif,
  output logic [3:0] ctrl_o
);
  // Writable control bits
  logic [3:0] ctrl_q;

  // ***************************************
  // Control bits
  // ***************************************
  // Reserved bits drop on write
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ctrl_q <= 4'h0;
    end else if (pif.wr_en) begin
      ctrl_q <= pif.wdata[3:0];
    end
  end

  assign ctrl_o = ctrl_q;

  // Read-back: lock flags live, reserved zero
  always_comb begin
    pif.rdata = {1'b0, pif.rx_lock, pif.sys_lock, 1'b0, ctrl_q};
  end
endmodule
`default_nettype wire

// File: test/ppe_bank_properties.sv
// Port checks of the PLL enable bank
`default_nettype none
module ppe_bank_properties #(
  parameter logic [15:0] DESIGN_ID = 16'h5a00 // Arbitrary value
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic p0_rx_lock_i,
  input wire logic p0_sys_lock_i,
  input wire logic p0_xcvr_run_o,
  input wire logic p0_dpll_run_o,
  input wire logic p0_sys_pll_en_o,
  input wire logic p0_ram_run_o,
  input wire logic p1_xcvr_run_o,
  input wire logic p1_dpll_run_o,
  input wire logic p1_sys_pll_en_o,
  input wire logic irq_o
);
  // ****
  // Data phase tracking
  // ****
  logic ph_q; // Transfer in data phase
  logic wr_q; // That transfer writes
  logic [7:0] ix_q; // Its register index
  // Latch the address phase when the bus moves on
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ph_q <= 1'b0;
      wr_q <= 1'b0;
      ix_q <= 8'h00;
    end else if (hready_i) begin
      ph_q <= hsel_i & htrans_i[1];
      wr_q <= hwrite_i;
      ix_q <= haddr_i[9:2];
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_rd; hready_i && hsel_i && htrans_i[1] && !hwrite_i; endsequence
  sequence s_wr; hready_i && hsel_i && htrans_i[1] && hwrite_i; endsequence
  sequence s_wait_data; !hreadyout_o ##1 hreadyout_o; endsequence
  // ****
  // Assertions
  // ****
  a_resp_okay: assert property (hresp_o == 1'b0)
    else $error("response not okay");
  a_write_no_wait: assert property (s_wr |=> hreadyout_o)
    else $error("write stalled");
  a_read_one_wait: assert property (s_rd |=> s_wait_data)
    else $error("read wait state wrong");
  a_reset_quiet: assert property (disable iff (1'b0) !reset_n_i |=> hreadyout_o && !irq_o
    && !p0_xcvr_run_o && !p0_ram_run_o && !p1_xcvr_run_o) else $error("reset state wrong");
  a_port0_ctrl: assert property (ph_q && wr_q && hready_i && ix_q == 8'h24 |=> ##1
    {p0_ram_run_o, p0_sys_pll_en_o, p0_dpll_run_o, p0_xcvr_run_o} == $past(hwdata_i[3:0], 2))
    else $error("port 0 controls wrong");
  a_port1_ctrl: assert property (ph_q && wr_q && hready_i && ix_q == 8'h34 |=> ##1
    {p1_sys_pll_en_o, p1_dpll_run_o, p1_xcvr_run_o} == $past(hwdata_i[2:0], 2))
    else $error("port 1 controls wrong");
  a_lock_read: assert property (ph_q && !wr_q && !hreadyout_o && ix_q == 8'h24 |=>
    hrdata_o[31:4] == {25'h0, $past(p0_rx_lock_i), $past(p0_sys_lock_i), 1'b0})
    else $error("lock read-back wrong");
  a_id_read: assert property (ph_q && !wr_q && !hreadyout_o && ix_q == 8'h7c |=>
    hrdata_o == {16'h0000, DESIGN_ID}) else $error("design id wrong");
endmodule
bind ppe_bank ppe_bank_properties #(.DESIGN_ID(DESIGN_ID)) i_ppe_bank_properties (.*);
`default_nettype wire

// File: test/ppe_pll_model.sv
// Lock model of one port's receive and system clock loops
`default_nettype none
module ppe_pll_model #(
  parameter int LOCK_CYC = 20 // Cycles from enable to lock
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic xcvr_run_i,
  input wire logic system_pll_enable_i,
  output logic rx_lock_o,
  output logic sys_lock_o
);
  int rx_cnt_q; // Cycles the receive loop has run
  int sys_cnt_q; // Cycles the system loop has run
  // Lock after settling, lose it at once when disabled
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i || !xcvr_run_i) rx_cnt_q <= 0;
    else if (rx_cnt_q < LOCK_CYC) rx_cnt_q <= rx_cnt_q + 1;
    if (!reset_n_i || !system_pll_enable_i) sys_cnt_q <= 0;
    else if (sys_cnt_q < LOCK_CYC) sys_cnt_q <= sys_cnt_q + 1;
  end
  assign rx_lock_o = (rx_cnt_q == LOCK_CYC);
  assign sys_lock_o = (sys_cnt_q == LOCK_CYC);
endmodule
`default_nettype wire

// File: test/test_port_pll_enable_indirect_regs.sv
// Self-checking bench of the PLL enable bank
`default_nettype none
module test_port_pll_enable_indirect_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LC = 20; // Slow loop settle time
  localparam logic [15:0] ID = 16'h3c00; // Arbitrary value
  logic clk_sys_i, reset_n_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, irq_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rv;
  logic [1:0] htrans_i;
  logic hsel_b, tgt_b; // Select of the bank without indirect registers, transfers go there
  wire hready, hreadyout_b; // Bus ready, ready of that bank
  wire [31:0] hrdata_b; // Read data of that bank
  logic [3:0] p0v; // Last value written to port 0
  wire [3:0] c0; // Port 0 controls
  wire [2:0] c1; // Port 1 controls
  wire l0r, l0s, l1r, l1s; // Lock levels
  logic [7:0] v, ix;
  logic [23:0] ia;
  logic [15:0] dd;
  int n_mismatch = 0, n_checks = 0;
  ppe_bank #(.HAS_INDIRECT(1'b1), .DESIGN_ID(ID)) i_ppe_bank (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hready),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .p0_rx_lock_i(l0r),
    .p0_sys_lock_i(l0s), .p1_rx_lock_i(l1r), .p1_sys_lock_i(l1s), .p0_xcvr_run_o(c0[0]),
    .p0_dpll_run_o(c0[1]), .p0_sys_pll_en_o(c0[2]), .p0_ram_run_o(c0[3]),
    .p1_xcvr_run_o(c1[0]), .p1_dpll_run_o(c1[1]), .p1_sys_pll_en_o(c1[2]), .irq_o(irq_o));
  // Second bank built without the indirect registers
  ppe_bank #(.HAS_INDIRECT(1'b0), .DESIGN_ID(ID)) i_ppe_bank_b (.clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .hsel_i(hsel_b), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hready),
    .hrdata_o(hrdata_b), .hreadyout_o(hreadyout_b), .hresp_o(), .p0_rx_lock_i(1'b0),
    .p0_sys_lock_i(1'b0), .p1_rx_lock_i(1'b0), .p1_sys_lock_i(1'b0), .p0_xcvr_run_o(),
    .p0_dpll_run_o(), .p0_sys_pll_en_o(), .p0_ram_run_o(), .p1_xcvr_run_o(),
    .p1_dpll_run_o(), .p1_sys_pll_en_o(), .irq_o());
  // Bus ready follows the bank that owns the transfer
  assign hready = tgt_b ? hreadyout_b : hreadyout_o;
  ppe_pll_model #(.LOCK_CYC(LC)) i_pll_p0 (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .xcvr_run_i(c0[0]), .system_pll_enable_i(c0[2]), .rx_lock_o(l0r), .sys_lock_o(l0s));
  ppe_pll_model #(.LOCK_CYC(3)) i_pll_p1 (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .xcvr_run_i(c1[0]), .system_pll_enable_i(c1[2]), .rx_lock_o(l1r), .sys_lock_o(l1s));
  // Clock
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single AHB transfer, read data left in rv
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel_i <= !tgt_b;
    hsel_b <= tgt_b;
    htrans_i <= 2'b10;
    hwrite_i <= w;
    haddr_i <= {22'h0, a, 2'b00};
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    hsel_i <= 1'b0;
    hsel_b <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    @(posedge clk_sys_i);
    while (hready !== 1'b1) @(posedge clk_sys_i);
    rv = tgt_b ? hrdata_b : hrdata_o;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rv);
  endtask
  // Enable read-back once both loops have settled
  function automatic logic [31:0] exp_en(input logic [7:0] w);
    return {25'h0, w[0], w[2], 1'b0, w[3:0]};
  endfunction
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    reset_n_i = 1'b0;
    hsel_i = 1'b0;
    hsel_b = 1'b0;
    tgt_b = 1'b0;
    htrans_i = 2'b00;
    hwrite_i = 1'b0;
    haddr_i = 32'h0;
    hwdata_i = 32'h0;
    void'($urandom(19372));
    repeat (16) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_chk("en0", 8'h24, 32'h0);
    rd_chk("id", 8'h7c, {16'h0, ID});
    rd_chk("load", 8'h40, 32'h0);
    // Loops brought up one after another
    for (int i = 0; i < 4; i++) begin
      v = 8'h0f >> (3 - i);
      xfer(1'b1, 8'h24, {24'h0, v});
      repeat (LC + 4) @(posedge clk_sys_i);
      chk("ctl0", {28'h0, v[3:0]}, {28'h0, c0});
      rd_chk("en0", 8'h24, exp_en(v));
    end
    // Random values on both ports, reserved bits included
    for (int i = 0; i < 12; i++) begin
      v = 8'($urandom());
      ix = (i % 2) ? 8'h34 : 8'h24;
      if (!(i % 2)) p0v = v[3:0];
      xfer(1'b1, ix, {24'h0, v});
      repeat (LC + 4) @(posedge clk_sys_i);
      chk("ctl0", {28'h0, p0v}, {28'h0, c0});
      if (i % 2) chk("ctl1", {29'h0, v[2:0]}, {29'h0, c1});
      rd_chk("en", ix, exp_en(v));
    end
    // Interrupt raised by a lock change, masked and cleared
    xfer(1'b1, 8'h24, 32'h0);
    repeat (LC + 4) @(posedge clk_sys_i);
    xfer(1'b1, 8'h70, 32'hf);
    xfer(1'b1, 8'h71, 32'h1);
    xfer(1'b1, 8'h24, 32'h1);
    repeat (LC + 4) @(posedge clk_sys_i);
    chk("irq", 32'h1, {31'h0, irq_o});
    rd_chk("ist", 8'h70, 32'h1);
    xfer(1'b1, 8'h71, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    chk("irq", 32'h0, {31'h0, irq_o});
    xfer(1'b1, 8'h71, 32'h1);
    xfer(1'b1, 8'h70, 32'h1);
    repeat (2) @(posedge clk_sys_i);
    chk("irq", 32'h0, {31'h0, irq_o});
    rd_chk("ist", 8'h70, 32'h0);
    // Indirect address bytes and data at two addresses
    ia = 24'($urandom());
    dd = 16'($urandom());
    for (int b = 0; b < 3; b++) xfer(1'b1, 8'h60 + 8'(b), {24'h0, ia[8*b +: 8]});
    xfer(1'b1, 8'h63, {24'h0, dd[7:0]});
    for (int b = 0; b < 3; b++) rd_chk("iadr", 8'h60 + 8'(b), {24'h0, ia[8*b +: 8]});
    xfer(1'b1, 8'h60, {24'h0, ia[7:0] ^ 8'h01});
    xfer(1'b1, 8'h63, {24'h0, dd[15:8]});
    rd_chk("idat", 8'h63, {24'h0, dd[15:8]});
    xfer(1'b1, 8'h60, {24'h0, ia[7:0]});
    rd_chk("idat", 8'h63, {24'h0, dd[7:0]});
    // Bank without the option: indirect registers absent, id still there
    tgt_b = 1'b1;
    xfer(1'b1, 8'h60, 32'h5a);
    xfer(1'b1, 8'h63, 32'ha5);
    rd_chk("noind_adr", 8'h60, 32'h0);
    rd_chk("noind_dat", 8'h63, 32'h0);
    rd_chk("noind_id", 8'h7c, {16'h0, ID});
    report_and_stop();
  end
endmodule
`default_nettype wire
